/* File: core/pin_function_mux_pkg.sv */
// package for the multi-purpose pin function multiplexer
// assumes one clock domain and plain configuration ports, no register bus
package pin_function_mux_pkg;

   // function select codes: primary, numbered alternates, general purpose
   localparam int unsigned FSEL_W        = 3;
   localparam logic [2:0]  FSEL_PRIMARY  = 3'h0;
   localparam logic [2:0]  FSEL_GPIO     = 3'h5;
   localparam logic [2:0]  FSEL_LOOPBACK = 3'h7;

   // pad electrical field layout
   localparam int unsigned PAD_SLEW_POS  = 0;
   localparam int unsigned PAD_DRV_POS   = 1;
   localparam int unsigned PAD_PULL_POS  = 3;
   localparam int unsigned PAD_W         = 5;

   // reset values
   localparam logic [2:0]  FSEL_RST      = 3'h0;
   localparam logic        ISEL_RST      = 1'h0;
   localparam logic [4:0]  PAD_RST       = 5'h00;
   localparam logic [31:0] INUSE_RST     = 32'h0000_0000;
   localparam logic [31:0] PULLUP_RST    = 32'h0000_0000;
   localparam int unsigned PORT_W        = 32;

   // pull encodings
   localparam logic [1:0]  PULL_NONE     = 2'h0;
   localparam logic [1:0]  PULL_UP       = 2'h1;
   localparam logic [1:0]  PULL_DOWN     = 2'h2;

   // pad settings as delivered to one pad
   typedef struct packed {
      logic [1:0] pull;
      logic [1:0] drive;
      logic       slew_fast;
   } pad_electrical_control_t;

   // configuration modes of the port-based special routing
   typedef enum logic [4:0] {
      SRC_DATA = 5'b00001,
      SRC_A_IN = 5'b00010,
      SRC_B_IN = 5'b00100,
      SRC_C_IN = 5'b01000,
      SRC_RSVD = 5'b10000
   } out_source_t;

endpackage : pin_function_mux_pkg

/* File: core/pin_function_mux.sv */
// pin function multiplexer: iomux scheme and port-based scheme in one block
// assumes pads are synchronous to i_ref_clk; peripherals sit on the other side
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - each pin goes to a peripheral function or to general purpose control
// - functional pins choose primary or one of several alternate functions
// - numbered alternate modes; mode 5 selects the general purpose port bit
// - pins fixed at integration stay dedicated; software writes leave their function select and pad settings unchanged
// - per-pin function select picks function and enables loopback if supported
// - input path select chooses which pad feeds a shared peripheral input
// - per-pad slew, drive strength and pull settings are applied to pads
// - functional pins other than loopback are driven by peripherals, general ones by port logic
// - in-use bit per pin steers between peripheral and general purpose
// - each port has its own 32-bit in-use register, one bit per pin
// - port-based functional pin offers only major or one alternate function
// - special configs: output from A/B/C input paths or data, input to A/B out
// - one pull-up enable register per port, one bit per pin
// - general output drives written level; input level is readable
module pin_function_mux #(
   parameter int unsigned NPINS   = 4,
   parameter int unsigned NALT    = 7,
   parameter int unsigned PORT_W  = pin_function_mux_pkg::PORT_W,
   parameter logic [3:0]  FIXED   = 4'h0,
   parameter logic [3:0]  LOOP_OK = 4'hF
) (
   // clock and control
   input  wire logic                                       i_ref_clk,
   input  wire logic                                       i_rst,
   input  wire logic                                       i_ce,
   // iomux scheme configuration, one write per pin
   input  wire logic                                       i_cfg_we,
   input  wire logic [1:0]                                 i_cfg_pin,
   input  wire logic [2:0]                                 i_pin_function_select,
   input  wire logic                                       i_input_path_select,
   input  wire pin_function_mux_pkg::pad_electrical_control_t i_pad_electrical_control,
   // peripheral side, one output/enable per alternate per pin
   input  wire logic [NPINS-1:0][NALT-1:0]                 i_periph_out,
   input  wire logic [NPINS-1:0][NALT-1:0]                 i_periph_oe,
   output logic                                            o_shared_periph_in,
   output logic [NPINS-1:0]                                o_periph_in,
   // general purpose data of the iomux pins
   input  wire logic [NPINS-1:0]                           i_gp_data,
   input  wire logic [NPINS-1:0]                           i_gp_dir_out,
   output logic [NPINS-1:0]                                o_gp_level,
   // iomux pads, output enable low while driving
   input  wire logic [NPINS-1:0]                           i_pad_in,
   output logic [NPINS-1:0]                                o_pad_out,
   output logic [NPINS-1:0]                                o_pad_oe_n,
   output pin_function_mux_pkg::pad_electrical_control_t [NPINS-1:0] o_pad_ctl,
   // port-based scheme configuration
   input  wire logic                                       i_inuse_we,
   input  wire logic [PORT_W-1:0]                          i_inuse_wdata,
   input  wire logic                                       i_pullup_we,
   input  wire logic [PORT_W-1:0]                          i_pullup_wdata,
   input  wire logic                                       i_data_we,
   input  wire logic [PORT_W-1:0]                          i_data_wdata,
   input  wire logic [PORT_W-1:0]                          i_port_dir_out,
   input  wire logic                                       i_spec_we,
   input  wire logic [4:0]                                 i_spec_src,
   input  wire logic                                       i_spec_in_to_b,
   input  wire logic [PORT_W-1:0]                          i_spec_mask,
   output logic [PORT_W-1:0]                               o_inuse,
   output logic [PORT_W-1:0]                               o_port_pullup_enable,
   output logic [PORT_W-1:0]                               o_port_level,
   // port-based peripheral side: major function and special paths
   input  wire logic [PORT_W-1:0]                          i_major_out,
   input  wire logic [PORT_W-1:0]                          i_major_oe,
   input  wire logic [PORT_W-1:0]                          i_a_in,
   input  wire logic [PORT_W-1:0]                          i_b_in,
   input  wire logic [PORT_W-1:0]                          i_c_in,
   output logic [PORT_W-1:0]                               o_a_out,
   output logic [PORT_W-1:0]                               o_b_out,
   // port-based pads
   input  wire logic [PORT_W-1:0]                          i_port_pad_in,
   output logic [PORT_W-1:0]                               o_port_pad_out,
   output logic [PORT_W-1:0]                               o_port_pad_oe_n
);

   logic [NPINS-1:0][2:0] fsel_q;
   logic                  isel_q;
   logic [PORT_W-1:0]     inuse_q;
   logic [PORT_W-1:0]     pullup_q;
   logic [PORT_W-1:0]     data_q;
   logic [PORT_W-1:0]     spec_q;
   logic                  spec_to_b_q;
   pin_function_mux_pkg::out_source_t src_q;
   logic [NPINS-1:0]      gp_level_q;
   logic [PORT_W-1:0]     port_level_q;

   // decode: functional when not the general purpose code
   function automatic logic is_gp(input logic [2:0] f);
      return f == pin_function_mux_pkg::FSEL_GPIO;
   endfunction

   // iomux configuration storage
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         logic wr;
         logic lb;
         assign wr = i_cfg_we && (i_cfg_pin == 2'(gi)) && !FIXED[gi];
         always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
               fsel_q[gi] <= pin_function_mux_pkg::FSEL_RST;
               o_pad_ctl[gi] <= pin_function_mux_pkg::PAD_RST;
            end else if (i_ce && wr) begin
               // loopback code only sticks on pins that support it
               if (i_pin_function_select != pin_function_mux_pkg::FSEL_LOOPBACK
                   || LOOP_OK[gi]) begin
                  fsel_q[gi] <= i_pin_function_select;
               end
               o_pad_ctl[gi] <= i_pad_electrical_control;
            end
         end
         assign lb = (fsel_q[gi] == pin_function_mux_pkg::FSEL_LOOPBACK);
         always_comb begin
            if (is_gp(fsel_q[gi])) begin
               o_pad_out[gi]  = i_gp_data[gi];
               o_pad_oe_n[gi] = !i_gp_dir_out[gi];
            end else if (lb) begin
               o_pad_out[gi]  = 1'b0;
               o_pad_oe_n[gi] = 1'b1;
            end else begin
               o_pad_out[gi]  = i_periph_out[gi][fsel_q[gi]];
               o_pad_oe_n[gi] = !i_periph_oe[gi][fsel_q[gi]];
            end
            // loopback feeds the primary output straight back inside
            o_periph_in[gi] = lb ? i_periph_out[gi][0]
                                 : (!is_gp(fsel_q[gi]) && i_pad_in[gi]);
         end
      end
   endgenerate

   // input path select for pads 0 and 1 sharing one peripheral input
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         isel_q <= pin_function_mux_pkg::ISEL_RST;
      end else if (i_ce && i_cfg_we && i_cfg_pin[1] == 1'b0) begin
         isel_q <= i_input_path_select;
      end
   end
   assign o_shared_periph_in = isel_q ? i_pad_in[1] : i_pad_in[0];

   // general purpose level capture
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         gp_level_q   <= '0;
         port_level_q <= '0;
      end else if (i_ce) begin
         gp_level_q   <= i_pad_in;
         port_level_q <= i_port_pad_in;
      end
   end
   assign o_gp_level   = gp_level_q;
   assign o_port_level = port_level_q;

   // port-based registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         inuse_q  <= pin_function_mux_pkg::INUSE_RST;
         pullup_q <= pin_function_mux_pkg::PULLUP_RST;
         data_q   <= '0;
      end else if (i_ce) begin
         if (i_inuse_we) begin
            inuse_q <= i_inuse_wdata;
         end
         if (i_pullup_we) begin
            pullup_q <= i_pullup_wdata;
         end
         if (i_data_we) begin
            data_q <= i_data_wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         spec_q      <= '0;
         spec_to_b_q <= 1'b0;
         src_q       <= pin_function_mux_pkg::SRC_DATA;
      end else if (i_ce && i_spec_we) begin
         spec_q      <= i_spec_mask;
         spec_to_b_q <= i_spec_in_to_b;
         case (i_spec_src)
            5'h01:   src_q <= pin_function_mux_pkg::SRC_DATA;
            5'h02:   src_q <= pin_function_mux_pkg::SRC_A_IN;
            5'h04:   src_q <= pin_function_mux_pkg::SRC_B_IN;
            5'h08:   src_q <= pin_function_mux_pkg::SRC_C_IN;
            default: src_q <= pin_function_mux_pkg::SRC_DATA;
         endcase
      end
   end
   assign o_inuse              = inuse_q;
   assign o_port_pullup_enable = pullup_q;

   // port pin steering: set in-use bit means peripheral (major) function
   logic [PORT_W-1:0] spec_out;
   always_comb begin
      case (src_q)
         pin_function_mux_pkg::SRC_A_IN: spec_out = i_a_in;
         pin_function_mux_pkg::SRC_B_IN: spec_out = i_b_in;
         pin_function_mux_pkg::SRC_C_IN: spec_out = i_c_in;
         default:                        spec_out = data_q;
      endcase
   end

   always_comb begin
      for (int b = 0; b < PORT_W; b++) begin
         if (inuse_q[b]) begin
            o_port_pad_out[b]  = i_major_out[b];
            o_port_pad_oe_n[b] = !i_major_oe[b];
         end else begin
            o_port_pad_out[b]  = spec_q[b] ? spec_out[b] : data_q[b];
            o_port_pad_oe_n[b] = !i_port_dir_out[b];
         end
      end
   end
   assign o_a_out = i_port_pad_in & spec_q & ~inuse_q & {PORT_W{!spec_to_b_q}};
   assign o_b_out = i_port_pad_in & spec_q & ~inuse_q & {PORT_W{spec_to_b_q}};

   // checks
   // any write aimed at a fixed pin must leave every function select and pad setting untouched
   property p_fixed_pin;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_cfg_we && FIXED[i_cfg_pin]
         |=> fsel_q == $past(fsel_q) && o_pad_ctl == $past(o_pad_ctl);
   endproperty
   a_fixed_pin: assert property (p_fixed_pin) else $error("fixed pin changed");

   property p_fsel_write;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_ce && i_cfg_we && i_cfg_pin == 2'h1 && !FIXED[1]
         && i_pin_function_select != pin_function_mux_pkg::FSEL_LOOPBACK
         |=> fsel_q[1] == $past(i_pin_function_select);
   endproperty
   a_fsel_write: assert property (p_fsel_write) else $error("select not stored");

   property p_gp_route;
      @(posedge i_ref_clk) disable iff (i_rst)
         is_gp(fsel_q[0]) |-> o_pad_out[0] == i_gp_data[0];
   endproperty
   a_gp_route: assert property (p_gp_route) else $error("mode 5 not general");

   property p_periph_route;
      @(posedge i_ref_clk) disable iff (i_rst)
         fsel_q[0] == pin_function_mux_pkg::FSEL_PRIMARY
         |-> o_pad_out[0] == i_periph_out[0][0];
   endproperty
   a_periph_route: assert property (p_periph_route) else $error("primary not routed");

   property p_inuse;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_ce && i_inuse_we |=> o_inuse == $past(i_inuse_wdata);
   endproperty
   a_inuse: assert property (p_inuse) else $error("in-use not stored");

   property p_steer;
      @(posedge i_ref_clk) disable iff (i_rst)
         inuse_q[0] |-> o_port_pad_out[0] == i_major_out[0];
   endproperty
   a_steer: assert property (p_steer) else $error("in-use steering wrong");

   property p_pullup;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_ce && i_pullup_we |=> o_port_pullup_enable == $past(i_pullup_wdata);
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up not stored");

   property p_level;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_ce |=> o_port_level == $past(i_port_pad_in);
   endproperty
   a_level: assert property (p_level) else $error("level not captured");

   property p_reset;
      @(posedge i_ref_clk) i_rst |=> fsel_q[0] == pin_function_mux_pkg::FSEL_RST && o_inuse == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");

   c_gp: cover property (@(posedge i_ref_clk) is_gp(fsel_q[1]));
   c_loop: cover property (@(posedge i_ref_clk) fsel_q[0] == pin_function_mux_pkg::FSEL_LOOPBACK);
   c_inuse: cover property (@(posedge i_ref_clk) inuse_q[3] && spec_q[4]);

endmodule // pin_function_mux
`default_nettype wire

/* File: sim/pad_ring_model.sv */
// pad ring partner: resolves pad wires from design drive, pulls and far-side level
// assumes design pad outputs are combinational and settle within the cycle
`timescale 1ns/100ps
`default_nettype none
module pad_ring_model (
   // iomux pads from the design
   input  wire logic [3:0]                                    i_pad_out,
   input  wire logic [3:0]                                    i_pad_oe_n,
   input  wire pin_function_mux_pkg::pad_electrical_control_t [3:0] i_pad_ctl,
   // port pads from the design
   input  wire logic [31:0]                                   i_port_out,
   input  wire logic [31:0]                                   i_port_oe_n,
   input  wire logic [31:0]                                   i_pullup,
   // far-side drivers, seen only while the design releases
   input  wire logic [3:0]                                    i_ext,
   input  wire logic [31:0]                                   i_port_ext,
   // resolved wire levels
   output logic [3:0]                                         o_pad,
   output logic [31:0]                                        o_port_pad
);
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!i_pad_oe_n[i])
            o_pad[i] = i_pad_out[i];
         else if (i_pad_ctl[i].pull == pin_function_mux_pkg::PULL_UP)
            o_pad[i] = 1'b1;
         else if (i_pad_ctl[i].pull == pin_function_mux_pkg::PULL_DOWN)
            o_pad[i] = 1'b0;
         else
            o_pad[i] = i_ext[i];
      end
      // a pulled-up port pad beats the far side
      o_port_pad = (~i_port_oe_n & i_port_out) | (i_port_oe_n & (i_pullup | i_port_ext));
   end
endmodule // pad_ring_model
`default_nettype wire

/* File: sim/pin_function_mux_tb.sv */
// bench for pin_function_mux: random configs checked against tracked expected state
// assumes pad_ring_model closes the pad wires
`timescale 1ns/100ps
`default_nettype none
module pin_function_mux_tb;
   localparam logic [3:0] FIXED_PINS = 4'h8;
   localparam logic [3:0] LOOP_PINS = 4'hB;
   localparam logic [2:0] GP = pin_function_mux_pkg::FSEL_GPIO;
   localparam logic [2:0] LB = pin_function_mux_pkg::FSEL_LOOPBACK;
   typedef pin_function_mux_pkg::pad_electrical_control_t pctl_t;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_cfg_we = 1'b0, i_inuse_we = 1'b0;
   logic i_pullup_we = 1'b0, i_data_we = 1'b0, i_spec_we = 1'b0, i_spec_in_to_b = 1'b0;
   logic i_input_path_select = 1'b0, o_shared_periph_in, is_e, sb_e;
   logic [1:0] i_cfg_pin = 2'h0;
   logic [2:0] i_pin_function_select = 3'h0;
   logic [2:0] fs_e [4];
   logic [4:0] i_spec_src = 5'h01, sp_e;
   logic [4:0] srcs [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   pctl_t i_pad_electrical_control = '0;
   pctl_t [3:0] o_pad_ctl, pc_e;
   logic [3:0][6:0] i_periph_out = '0, i_periph_oe = '0;
   logic [3:0] i_gp_data = '0, i_gp_dir_out = '0, ext = '0, i_pad_in, o_gp_level, lv, lm;
   logic [3:0] o_periph_in, o_pad_out, o_pad_oe_n;
   logic [31:0] i_inuse_wdata = '0, i_pullup_wdata = '0, i_data_wdata = '0, i_spec_mask = '0;
   logic [31:0] i_port_dir_out = '0, i_major_out = '0, i_major_oe = '0, i_a_in = '0;
   logic [31:0] i_b_in = '0, i_c_in = '0, pext = '0, i_port_pad_in, o_inuse, o_port_level;
   logic [31:0] o_port_pullup_enable, o_a_out, o_b_out, o_port_pad_out, o_port_pad_oe_n;
   logic [31:0] iu_e, pu_e, dt_e, sm_e, lvp;
   integer seed = 32'hBCC7C2BF;
   int err_count = 0, num_checks = 0;
   int kq[$];
   logic [31:0] eq[$], mq[$];
   string nm[13] = '{"pad_out", "pad_oe_n", "periph_in", "pad_ctl", "gp_level", "shared_in",
      "inuse", "pullup", "port_out", "port_oe_n", "port_level", "a_out", "b_out"};

   pin_function_mux #(.FIXED(FIXED_PINS), .LOOP_OK(LOOP_PINS)) u_dut (.*);
   pad_ring_model u_pads (.i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n), .i_pad_ctl(o_pad_ctl),
      .i_port_out(o_port_pad_out), .i_port_oe_n(o_port_pad_oe_n), .i_pullup(o_port_pullup_enable),
      .i_ext(ext), .i_port_ext(pext), .o_pad(i_pad_in), .o_port_pad(i_port_pad_in));

   always #2 i_ref_clk = ~i_ref_clk;

   function automatic logic [31:0] got(input int k);
      case (k)
         0: return 32'(o_pad_out);
         1: return 32'(o_pad_oe_n);
         2: return 32'(o_periph_in);
         3: return 32'(o_pad_ctl);
         4: return 32'(o_gp_level);
         5: return 32'(o_shared_periph_in);
         6: return o_inuse;
         7: return o_port_pullup_enable;
         8: return o_port_pad_out;
         9: return o_port_pad_oe_n;
         10: return o_port_level;
         11: return o_a_out;
         default: return o_b_out;
      endcase
   endfunction

   task automatic cmp(input int k, input logic [31:0] e, input logic [31:0] m);
      num_checks++;
      if ((got(k) & m) !== (e & m)) begin
         err_count++;
         $display("unexpected %s exp %h got %h", nm[k], e & m, got(k) & m);
      end
   endtask

   // all queued notes are judged, oldest first, once the outputs have settled
   always @(negedge i_ref_clk)
      while (kq.size() > 0) cmp(kq.pop_front(), eq.pop_front(), mq.pop_front());

   task automatic note(input int k, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      kq.push_back(k);
      eq.push_back(e);
      mq.push_back(m);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      fs_e = '{default: 3'h0};
      {pc_e, is_e, sb_e, iu_e, pu_e, dt_e, sm_e, sp_e} = {22'h0, 128'h0, 5'h01};
   endtask

   task automatic rnd(input int i, output logic [4:0] w, output logic c);
      logic [31:0] r;
      @(posedge i_ref_clk);
      r = $random(seed);
      w = {1'b1, r[13:10]};
      c = r[16:14] != 3'h0;
      {i_gp_data, i_gp_dir_out, ext} <= r[31:20];
      i_periph_out <= 28'($random(seed));
      i_periph_oe <= 28'($random(seed));
      i_cfg_pin <= 2'(i >> 3);
      i_pin_function_select <= 3'(i);
      i_input_path_select <= r[0];
      i_pad_electrical_control <= pctl_t'({(r[2:1] == 2'h3) ? 2'h0 : r[2:1], r[5:3]});
      i_spec_src <= srcs[32'(r[19:17]) % 5];
      i_spec_in_to_b <= r[9];
      {i_inuse_wdata, i_pullup_wdata, i_data_wdata} <= {$random(seed), $random(seed), $random(seed)};
      {i_spec_mask, i_port_dir_out, pext} <= {$random(seed), $random(seed), $random(seed)};
      {i_major_out, i_major_oe, i_a_in} <= {$random(seed), $random(seed), $random(seed)};
      {i_b_in, i_c_in} <= {$random(seed), $random(seed)};
   endtask

   task automatic pulse(input logic [4:0] w, input logic c);
      @(posedge i_ref_clk);
      {i_cfg_we, i_spec_we, i_data_we, i_pullup_we, i_inuse_we} <= w;
      i_ce <= c;
      @(posedge i_ref_clk);
      {i_cfg_we, i_spec_we, i_data_we, i_pullup_we, i_inuse_we} <= 5'h00;
      i_ce <= 1'b1;
   endtask

   task automatic check();
      logic [3:0] po, pob, pi;
      logic [31:0] so, sob, src;
      for (int p = 0; p < 4; p++) begin
         lm[p] = fs_e[p] != LB;
         // loopback releases the pad: no drive, level from pull or far side
         po[p] = (fs_e[p] == GP) ? i_gp_data[p] : lm[p] && i_periph_out[p][fs_e[p]];
         pob[p] = (fs_e[p] == GP) ? !i_gp_dir_out[p] : !(lm[p] && i_periph_oe[p][fs_e[p]]);
         lv[p] = !pob[p] ? po[p] : (pc_e[p].pull == 2'h1) | ((pc_e[p].pull == 2'h0) & ext[p]);
         pi[p] = lm[p] ? (fs_e[p] != GP) & lv[p] : i_periph_out[p][0];
      end
      case (sp_e)
         5'h02: src = i_a_in;
         5'h04: src = i_b_in;
         5'h08: src = i_c_in;
         default: src = dt_e;
      endcase
      so = (iu_e & i_major_out) | (~iu_e & ((sm_e & src) | (~sm_e & dt_e)));
      sob = ~((iu_e & i_major_oe) | (~iu_e & i_port_dir_out));
      lvp = (~sob & so) | (sob & (pu_e | pext));
      note(0, 32'(po));
      note(1, 32'(pob));
      note(2, 32'(pi));
      note(3, 32'(pc_e));
      note(5, 32'(lv[is_e]));
      note(6, iu_e);
      note(7, pu_e);
      note(8, so);
      note(9, sob);
      note(11, sb_e ? 32'h0 : lvp & sm_e & ~iu_e);
      note(12, sb_e ? lvp & sm_e & ~iu_e : 32'h0);
      @(posedge i_ref_clk);
      note(4, 32'(lv));
      note(10, lvp);
   endtask

   initial begin
      logic [4:0] w;
      logic c;
      do_reset();
      check();
      $display("reset test done");
      // every code on every pin, three rounds
      for (int i = 0; i < 96; i++) begin
         rnd(i, w, c);
         pulse(w, c);
         if (c) begin
            if (!FIXED_PINS[i_cfg_pin]) begin
               pc_e[i_cfg_pin] = i_pad_electrical_control;
               if (i_pin_function_select != LB || LOOP_PINS[i_cfg_pin])
                  fs_e[i_cfg_pin] = i_pin_function_select;
               if (i_cfg_pin < 2'h2)
                  is_e = i_input_path_select;
            end
            if (w[0]) iu_e = i_inuse_wdata;
            if (w[1]) pu_e = i_pullup_wdata;
            if (w[2]) dt_e = i_data_wdata;
            if (w[3]) {sp_e, sb_e, sm_e} = {i_spec_src, i_spec_in_to_b, i_spec_mask};
         end
         check();
      end
      $display("random config test done");
      do_reset();
      check();
      $display("second reset test done");
      // second negedge: the compare process has drained the last notes by then
      repeat (2) @(negedge i_ref_clk);
      tally_and_finish();
   end

   initial begin
      repeat (2000) @(posedge i_ref_clk);
      err_count++;
      tally_and_finish();
   end
endmodule // pin_function_mux_tb
`default_nettype wire
